// file: src/fctd_map.svh
// Purpose: register offsets, field positions, field values, response codes and counts for the transfer decoder
// Assumes: 32-bit register words on AXI4-Lite, byte addresses
// Notes: definitions only
`ifndef FCTD_MAP_SVH
`define FCTD_MAP_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define FCTD_CTRL_OFS     8'h00
`define FCTD_INSTR_OFS    8'h04
`define FCTD_BASE_OFS     8'h08
`define FCTD_STATUS_OFS   8'h0C
`define FCTD_RESULT_OFS   8'h10
`define FCTD_SRC_HI_OFS   8'h14
`define FCTD_SRC_LO_OFS   8'h18

// ****************************************************************
// field positions and values
// ****************************************************************
`define FCTD_CTRL_EXPDEC_BIT  0
`define FCTD_ST_BUSY_BIT      0
`define FCTD_ST_EMUL_BIT      1
`define FCTD_ST_WB_BIT        2
`define FCTD_ST_DONE_BIT      3
`define FCTD_COND_HI          31
`define FCTD_COND_LO          28
`define FCTD_CLASS_HI         27
`define FCTD_CLASS_LO         25
`define FCTD_PRE_BIT          24
`define FCTD_UP_BIT           23
`define FCTD_LEN_HI_BIT       22
`define FCTD_WB_BIT           21
`define FCTD_LOAD_BIT         20
`define FCTD_BASE_HI          19
`define FCTD_BASE_LO          16
`define FCTD_LEN_LO_BIT       15
`define FCTD_FREG_HI          14
`define FCTD_FREG_LO          12
`define FCTD_CP_HI            11
`define FCTD_CP_LO            8
`define FCTD_CLASS_XFER       3'h6
`define FCTD_CP_SINGLE        4'h1
`define FCTD_CP_GROUP         4'h2
`define FCTD_WORD_BYTES       32'h00000004
`define FCTD_WORDS_PER_REG    4'h3
`define FCTD_RESP_OKAY        2'h0
`define FCTD_RESP_SLVERR      2'h2
`define FCTD_ZERO_WORD        32'h00000000

`endif

// file: src/fctd_pkg.sv
// Purpose: types shared by the transfer decoder
// Assumes: nothing beyond the map header
// Notes: one-hot sequencer states
package fctd_pkg;

    typedef enum logic [1:0] {
        FCTD_IDLE = 2'b01,
        FCTD_RUN  = 2'b10
    } fctd_state_t;

    typedef logic [2:0] fctd_freg_t;

endpackage

// file: src/fctd_transfer_decoder.sv
// Purpose: decoder and address sequencer for float register memory transfers
// Assumes: host evaluates the condition field and moves the memory words itself
// Notes: one word per handshake on the XFER stream, through a two-entry buffer
`include "fctd_map.svh"

module fctd_transfer_decoder (
    input wire logic CLOCK_I,                  // 100 MHz clock
    input wire logic SRST_I,                   // sync reset, active high
    input wire logic [7:0] S_AXI_AWADDR_I,     // write address
    input wire logic S_AXI_AWVALID_I,          // write address valid
    output logic S_AXI_AWREADY_O,              // write address ready
    input wire logic [31:0] S_AXI_WDATA_I,     // write data
    input wire logic [3:0] S_AXI_WSTRB_I,      // byte enables
    input wire logic S_AXI_WVALID_I,           // write data valid
    output logic S_AXI_WREADY_O,               // write data ready
    output logic [1:0] S_AXI_BRESP_O,          // write response
    output logic S_AXI_BVALID_O,               // write response valid
    input wire logic S_AXI_BREADY_I,           // write response ready
    input wire logic [7:0] S_AXI_ARADDR_I,     // read address
    input wire logic S_AXI_ARVALID_I,          // read address valid
    output logic S_AXI_ARREADY_O,              // read address ready
    output logic [31:0] S_AXI_RDATA_O,         // read data
    output logic [1:0] S_AXI_RRESP_O,          // read response
    output logic S_AXI_RVALID_O,               // read data valid
    input wire logic S_AXI_RREADY_I,           // read data ready
    output logic XFER_VALID_O,                 // transfer word valid
    input wire logic XFER_READY_I,             // host takes the word
    output logic [31:0] XFER_ADDR_O,           // memory byte address
    output logic [31:0] XFER_DATA_O,           // store data, zero on load
    output logic XFER_LOAD_O,                  // 1 load, 0 store
    output fctd_pkg::fctd_freg_t XFER_FREG_O,  // float register of this word
    output logic XFER_LAST_O                   // last word of instruction
);
    import fctd_pkg::*;

    // ****************************************************************
    // functions
    // ****************************************************************
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // double to single, round to nearest even; out-of-range tiny values flush to zero
    function automatic logic [31:0] to_single(input logic [63:0] d);
        logic [31:0] r;
        logic [12:0] e;
        logic [31:0] base;
        logic up;
        r = {d[63], 31'h00000000};
        e = 13'({2'h0, d[62:52]}) - 13'h0380;
        base = {d[63], e[7:0], d[51:29]};
        up = d[28] & ((|d[27:0]) | d[29]);
        if (d[62:52] == 11'h7FF) begin
            r = {d[63], 8'hFF, d[51:29] | {22'h000000, |d[51:0]}};
        end else if (d[62:52] == 11'h000 || e[12] || e == 13'h0000) begin
            r = {d[63], 31'h00000000};
        end else if (e >= 13'h00FF) begin
            r = {d[63], 8'hFF, 23'h000000};
        end else begin
            r = base + {31'h00000000, up};
        end
        return r;
    endfunction

    // ****************************************************************
    // register bus
    // ****************************************************************
    logic aw_full_q, w_full_q, bvalid_q, rvalid_q, start_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q, rdata_q, instr_q, base_q, src_hi_q, src_lo_q, result_q;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q, rresp_q;
    logic expdec_q, emul_q, wb_q, done_q, busy;
    logic do_write, instr_hit;
    fctd_state_t state_q;

    assign S_AXI_AWREADY_O = !aw_full_q && !bvalid_q;
    assign S_AXI_WREADY_O = !w_full_q && !bvalid_q;
    assign S_AXI_BVALID_O = bvalid_q;
    assign S_AXI_BRESP_O = bresp_q;
    assign S_AXI_ARREADY_O = !rvalid_q;
    assign S_AXI_RVALID_O = rvalid_q;
    assign S_AXI_RDATA_O = rdata_q;
    assign S_AXI_RRESP_O = rresp_q;
    assign do_write = aw_full_q && w_full_q && !bvalid_q;
    assign instr_hit = awaddr_q == `FCTD_INSTR_OFS;

    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
        end else begin
            if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
                aw_full_q <= 1'b1;
                awaddr_q <= S_AXI_AWADDR_I;
            end else if (do_write) begin
                aw_full_q <= 1'b0;
            end
            if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
                w_full_q <= 1'b1;
                wdata_q <= S_AXI_WDATA_I;
                wstrb_q <= S_AXI_WSTRB_I;
            end else if (do_write) begin
                w_full_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            bvalid_q <= 1'b0;
            bresp_q <= `FCTD_RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q <= `FCTD_RESP_OKAY;
            case (awaddr_q)
                `FCTD_CTRL_OFS, `FCTD_BASE_OFS, `FCTD_SRC_HI_OFS, `FCTD_SRC_LO_OFS: begin
                    bresp_q <= `FCTD_RESP_OKAY;
                end
                `FCTD_INSTR_OFS: begin
                    if (busy) begin
                        bresp_q <= `FCTD_RESP_SLVERR;
                    end
                end
                default: begin
                    bresp_q <= `FCTD_RESP_SLVERR;
                end
            endcase
        end else if (S_AXI_BREADY_I) begin
            bvalid_q <= 1'b0;
        end
    end

    // software registers; an instruction write while busy is dropped
    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            expdec_q <= 1'b0;
            instr_q <= 32'h00000000;
            base_q <= 32'h00000000;
            src_hi_q <= 32'h00000000;
            src_lo_q <= 32'h00000000;
            start_q <= 1'b0;
        end else begin
            start_q <= do_write && instr_hit && !busy;
            if (do_write) begin
                case (awaddr_q)
                    `FCTD_CTRL_OFS: begin
                        if (wstrb_q[0]) begin
                            expdec_q <= wdata_q[`FCTD_CTRL_EXPDEC_BIT];
                        end
                    end
                    `FCTD_INSTR_OFS: begin
                        if (!busy) begin
                            instr_q <= merge(instr_q, wdata_q, wstrb_q);
                        end
                    end
                    `FCTD_BASE_OFS: begin
                        base_q <= merge(base_q, wdata_q, wstrb_q);
                    end
                    `FCTD_SRC_HI_OFS: begin
                        src_hi_q <= merge(src_hi_q, wdata_q, wstrb_q);
                    end
                    `FCTD_SRC_LO_OFS: begin
                        src_lo_q <= merge(src_lo_q, wdata_q, wstrb_q);
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= `FCTD_RESP_OKAY;
        end else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
            rvalid_q <= 1'b1;
            rresp_q <= `FCTD_RESP_OKAY;
            case (S_AXI_ARADDR_I)
                `FCTD_CTRL_OFS: rdata_q <= {31'h00000000, expdec_q};
                `FCTD_INSTR_OFS: rdata_q <= instr_q;
                `FCTD_BASE_OFS: rdata_q <= base_q;
                `FCTD_STATUS_OFS: rdata_q <= {28'h0000000, done_q, wb_q, emul_q, busy};
                `FCTD_RESULT_OFS: rdata_q <= result_q;
                `FCTD_SRC_HI_OFS: rdata_q <= src_hi_q;
                `FCTD_SRC_LO_OFS: rdata_q <= src_lo_q;
                default: begin
                    rdata_q <= 32'h00000000;
                    rresp_q <= `FCTD_RESP_SLVERR;
                end
            endcase
        end else if (S_AXI_RREADY_I) begin
            rvalid_q <= 1'b0;
        end
    end

    // ****************************************************************
    // instruction decode
    // ****************************************************************
    logic is_xfer, is_single, is_group, pre, up, wbit, load;
    logic [1:0] len;
    logic [31:0] offset, modified, first_addr;
    logic [3:0] total;

    assign is_xfer = instr_q[`FCTD_CLASS_HI:`FCTD_CLASS_LO] == `FCTD_CLASS_XFER;
    assign is_single = is_xfer && instr_q[`FCTD_CP_HI:`FCTD_CP_LO] == `FCTD_CP_SINGLE;
    assign is_group = is_xfer && instr_q[`FCTD_CP_HI:`FCTD_CP_LO] == `FCTD_CP_GROUP;
    assign pre = instr_q[`FCTD_PRE_BIT];
    assign up = instr_q[`FCTD_UP_BIT];
    assign wbit = instr_q[`FCTD_WB_BIT];
    assign load = instr_q[`FCTD_LOAD_BIT];
    assign len = {instr_q[`FCTD_LEN_HI_BIT], instr_q[`FCTD_LEN_LO_BIT]};
    assign offset = {22'h000000, instr_q[7:0], 2'b00};
    assign modified = up ? base_q + offset : base_q - offset;
    assign first_addr = pre ? modified : base_q;

    always_comb begin
        total = 4'h1;
        if (is_group) begin
            case (len)
                2'b01: total = `FCTD_WORDS_PER_REG;
                2'b10: total = 4'h6;
                2'b11: total = 4'h9;
                default: total = 4'hC;
            endcase
        end else begin
            case (len)
                2'b00: total = 4'h1;
                2'b01: total = 4'h2;
                2'b10: total = 4'h3;
                default: total = expdec_q ? 4'h4 : 4'h3;
            endcase
        end
    end

    // ****************************************************************
    // sequencer
    // ****************************************************************
    logic [31:0] addr_q, word_data;
    logic [3:0] widx_q, total_q;
    logic [1:0] sub_q;
    fctd_freg_t freg_q;
    logic load_q, group_q, single_q, push, last, in_ready;
    logic [1:0] len_q;

    assign push = state_q == FCTD_RUN && in_ready;
    assign last = widx_q == total_q - 4'h1;

    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            state_q <= FCTD_IDLE;
        end else begin
            case (state_q)
                FCTD_IDLE: begin
                    if (start_q && (is_single || is_group)) begin
                        state_q <= FCTD_RUN;
                    end
                end
                FCTD_RUN: begin
                    if (push && last) begin
                        state_q <= FCTD_IDLE;
                    end
                end
                default: state_q <= FCTD_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            addr_q <= 32'h00000000;
            widx_q <= 4'h0;
            total_q <= 4'h1;
            sub_q <= 2'h0;
            freg_q <= 3'h0;
            load_q <= 1'b0;
            group_q <= 1'b0;
            single_q <= 1'b0;
            len_q <= 2'h0;
        end else if (state_q == FCTD_IDLE && start_q) begin
            addr_q <= first_addr;
            widx_q <= 4'h0;
            total_q <= total;
            sub_q <= 2'h0;
            freg_q <= instr_q[`FCTD_FREG_HI:`FCTD_FREG_LO];
            load_q <= load;
            group_q <= is_group;
            single_q <= is_single;
            len_q <= len;
        end else if (push) begin
            addr_q <= addr_q + `FCTD_WORD_BYTES;
            widx_q <= widx_q + 4'h1;
            if (group_q && sub_q == 2'h2) begin
                sub_q <= 2'h0;
                freg_q <= freg_q + 3'h1;
            end else begin
                sub_q <= sub_q + 2'h1;
            end
        end
    end

    // single store rounds, wider formats pass exactly
    always_comb begin
        word_data = `FCTD_ZERO_WORD;
        if (!load_q) begin
            if (single_q && len_q == 2'b00) begin
                word_data = to_single({src_hi_q, src_lo_q});
            end else if (sub_q == 2'h0) begin
                word_data = src_hi_q;
            end else if (sub_q == 2'h1) begin
                word_data = src_lo_q;
            end
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            result_q <= 32'h00000000;
            emul_q <= 1'b0;
            wb_q <= 1'b0;
            done_q <= 1'b0;
        end else if (state_q == FCTD_IDLE && start_q) begin
            result_q <= wbit ? modified : base_q;
            wb_q <= wbit;
            emul_q <= !(is_single || is_group);
            done_q <= !(is_single || is_group);
        end else if (push && last) begin
            done_q <= 1'b1;
        end
    end

    // ****************************************************************
    // two-entry output buffer
    // ****************************************************************
    logic [68:0] buf_q [2];
    logic [1:0] cnt_q;
    logic wr_q, rd_q, pop;

    assign in_ready = cnt_q != 2'h2;
    assign pop = XFER_VALID_O && XFER_READY_I;
    assign XFER_VALID_O = cnt_q != 2'h0;
    assign {XFER_ADDR_O, XFER_DATA_O, XFER_LOAD_O, XFER_FREG_O, XFER_LAST_O} = buf_q[rd_q];
    assign busy = state_q == FCTD_RUN || cnt_q != 2'h0 || start_q;

    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            cnt_q <= 2'h0;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            buf_q[0] <= 69'h0;
            buf_q[1] <= 69'h0;
        end else begin
            if (push) begin
                buf_q[wr_q] <= {addr_q, word_data, load_q, freg_q, last};
                wr_q <= !wr_q;
            end
            if (pop) begin
                rd_q <= !rd_q;
            end
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (SRST_I);

    sequence s_start;
        state_q == FCTD_IDLE && start_q;
    endsequence

    sequence s_mid_push;
        push && !last;
    endsequence

    addr_step_a: assert property (s_mid_push |=> addr_q == $past(addr_q) + 32'h00000004)
        else $error("address did not step by one word");
    first_addr_a: assert property (s_start |=> addr_q == ($past(pre) ? $past(modified) : $past(base_q)))
        else $error("first address wrong");
    post_wb_a: assert property (s_start ##0 !wbit |=> result_q == $past(base_q))
        else $error("base changed without write-back bit");
    wb_value_a: assert property (s_start ##0 wbit |=> result_q == $past(modified) && wb_q)
        else $error("write-back value wrong");
    single_len_a: assert property (s_start ##0 is_single && len == 2'b11 |=> total_q == ($past(expdec_q) ? 4'h4 : 4'h3))
        else $error("decimal length wrong");
    group_len_a: assert property (s_start ##0 is_group && len == 2'b00 |=> total_q == 4'hC)
        else $error("group of four not twelve words");
    reg_wrap_a: assert property (push && group_q && sub_q == 2'h2 && !last |=> freg_q == $past(freg_q) + 3'h1)
        else $error("register order wrong");
    emul_skip_a: assert property (s_start ##0 !(is_single || is_group) |=> state_q == FCTD_IDLE ##0 emul_q)
        else $error("unsupported instruction was run");
    hold_out_a: assert property (XFER_VALID_O && !XFER_READY_I |=> XFER_VALID_O && $stable(XFER_ADDR_O))
        else $error("stalled word changed");
    store_dir_a: assert property (push && load_q |-> word_data == 32'h00000000)
        else $error("load carried store data");

endmodule

// file: tb/fctd_host_model.sv
// Purpose: host core model that takes transfer words from the decoder
// Assumes: one word per valid/ready handshake on the rising edge
// Notes: slow_i gives ready one cycle in four, stall_i holds it low
module fctd_host_model (
    input wire logic clk_i,          // clock
    input wire logic rst_i,          // sync reset, active high
    input wire logic stall_i,        // hold ready low
    input wire logic slow_i,         // thin out ready
    input wire logic valid_i,        // word valid
    output logic ready_o,            // word taken
    input wire logic [31:0] addr_i,  // byte address
    input wire logic [31:0] data_i,  // store data
    input wire logic [4:0] meta_i    // load, register, last
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] ph_q;
    logic [31:0] addr_q[$];
    logic [31:0] data_q[$];
    logic [4:0] meta_q[$];
    always_ff @(posedge clk_i) begin
        ph_q <= rst_i ? 2'h0 : ph_q + 2'h1;
        ready_o <= !rst_i && !stall_i && (!slow_i || ph_q == 2'h0);
    end
    // words kept in bus order for the bench
    always_ff @(posedge clk_i) begin
        if (!rst_i && valid_i && ready_o) begin
            addr_q.push_back(addr_i);
            data_q.push_back(data_i);
            meta_q.push_back(meta_i);
        end
    end
endmodule

// file: tb/tb_top.sv
// Purpose: self-checking bench for the transfer decoder
// Assumes: AXI4-Lite register access, host model on the word stream
// Notes: base register index 3, offsets at most 255 words
`include "fctd_map.svh"
`define HM i_fctd_host_model
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] BASE = 32'h00001000;
    localparam logic [31:0] HI = 32'h3FF00000;
    logic clk, rst, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic xv, xr, xl, xlast, stall, slow;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, xa, xd, lo, ins, d;
    logic [1:0] bresp, rresp, r;
    logic [2:0] xf;
    int n_errors, comparisons;
    fctd_transfer_decoder i_fctd_transfer_decoder (.CLOCK_I(clk), .SRST_I(rst),
        .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
        .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
        .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
        .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
        .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
        .XFER_VALID_O(xv), .XFER_READY_I(xr), .XFER_ADDR_O(xa), .XFER_DATA_O(xd),
        .XFER_LOAD_O(xl), .XFER_FREG_O(xf), .XFER_LAST_O(xlast));
    fctd_host_model i_fctd_host_model (.clk_i(clk), .rst_i(rst), .stall_i(stall), .slow_i(slow),
        .valid_i(xv), .ready_o(xr), .addr_i(xa), .data_i(xd), .meta_i({xl, xf, xlast}));
    task automatic stop_test();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
        int t;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        t = 0;
        do begin
            @(posedge clk);
            t++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!(bvalid && bready) && t < 100);
        rs = bresp;
        if (t >= 100) n_errors++;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        int t;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        t = 0;
        do begin
            @(posedge clk);
            t++;
            if (arready) arvalid <= 1'b0;
        end while (!(rvalid && rready) && t < 100);
        v = rdata;
        rs = rresp;
        if (t >= 100) n_errors++;
    endtask
    function automatic logic [31:0] ea(input logic [31:0] i);
        return i[23] ? BASE + {22'h0, i[7:0], 2'h0} : BASE - {22'h0, i[7:0], 2'h0};
    endfunction
    function automatic logic [31:0] mk(input logic p, u, y, wb, l, x, input logic [2:0] f,
        input logic [3:0] cp, input logic [7:0] off);
        return {4'hE, 3'b110, p, u, y, wb, l, 4'h3, x, f, cp, off};
    endfunction
    task automatic issue(input logic [31:0] i);
        `HM.addr_q.delete();
        `HM.data_q.delete();
        `HM.meta_q.delete();
        wr(`FCTD_INSTR_OFS, i, r);
        `CHK(r, `FCTD_RESP_OKAY)
    endtask
    task automatic collect(input logic [31:0] i, input int n);
        int t;
        logic [2:0] f;
        logic [31:0] e;
        t = 0;
        while (`HM.addr_q.size() < n && t < 400) begin
            @(posedge clk);
            t++;
        end
        repeat (4) @(posedge clk);
        `CHK(`HM.addr_q.size(), n)
        for (int k = 0; k < n && k < `HM.addr_q.size(); k++) begin
            f = i[14:12] + ((i[11:8] == 4'h2) ? 3'(k / 3) : 3'h0);
            e = (k % 3 == 0) ? HI : (k % 3 == 1) ? lo : 32'h0;
            `CHK(`HM.addr_q[k], (i[24] ? ea(i) : BASE) + 32'(4 * k))
            `CHK(`HM.meta_q[k], {i[20], f, 1'(k == n - 1)})
            if (i[20]) `CHK(`HM.data_q[k], 32'h0)
            else if (i[11:8] == 4'h2) `CHK(`HM.data_q[k], e)
        end
        rd(`FCTD_RESULT_OFS, d, r);
        `CHK(d, i[21] ? ea(i) : BASE)
    endtask
    task automatic run(input logic [31:0] i, input int n);
        issue(i);
        collect(i, n);
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        stop_test();
    end
    initial begin
        int lens[5] = '{1, 2, 3, 3, 4};
        logic [31:0] los[3] = '{32'h0, 32'h10000000, 32'h30000000};
        logic [31:0] rnd[3] = '{32'h3F800000, 32'h3F800000, 32'h3F800002};
        {rst, stall, slow} = 3'b100;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        {awaddr, araddr, wdata} = 48'h0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(`FCTD_STATUS_OFS, d, r);
        `CHK(d[0], 1'b0)
        rd(8'h1C, d, r);
        `CHK(r, `FCTD_RESP_SLVERR)
        wr(`FCTD_RESULT_OFS, 32'h1, r);
        `CHK(r, `FCTD_RESP_SLVERR)
        wr(`FCTD_BASE_OFS, BASE, r);
        wr(`FCTD_SRC_HI_OFS, HI, r);
        lo = 32'h0;
        wr(`FCTD_SRC_LO_OFS, lo, r);
        for (int k = 0; k < 5; k++) begin
            wr(`FCTD_CTRL_OFS, {31'h0, 1'(k == 4)}, r);
            run(mk(1, 1, k[1] | k[2], 1, 1, k[0] | k[2], 3'(k), 1, 8'(k + 1)), lens[k]);
        end
        wr(`FCTD_CTRL_OFS, 32'h0, r);
        run(mk(0, 0, 0, 0, 0, 1, 5, 1, 8'hFF), 2);
        `CHK(`HM.data_q[0], HI)
        `CHK(`HM.data_q[1], lo)
        run(mk(1, 0, 0, 1, 1, 0, 2, 1, 8'hFF), 1);
        for (int j = 0; j < 3; j++) begin
            lo = los[j];
            wr(`FCTD_SRC_LO_OFS, lo, r);
            run(mk(1, 1, 0, 0, 0, 0, 0, 1, 8'h0), 1);
            `CHK(`HM.data_q[0], rnd[j])
        end
        slow <= 1'b1;
        for (int c = 1; c < 5; c++) run(mk(0, 1, c[1] & ~c[2], 1, 0, c[0], 6, 2, 8'(c)), 3 * c);
        slow <= 1'b0;
        stall <= 1'b1;
        ins = mk(1, 1, 0, 0, 1, 0, 7, 2, 8'h4);
        issue(ins);
        repeat (20) @(posedge clk);
        wr(`FCTD_INSTR_OFS, ins, r);
        `CHK(r, `FCTD_RESP_SLVERR)
        stall <= 1'b0;
        collect(ins, 12);
        issue(mk(1, 1, 0, 0, 1, 0, 1, 3, 8'h0));
        repeat (10) @(posedge clk);
        rd(`FCTD_STATUS_OFS, d, r);
        `CHK(d[1], 1'b1)
        `CHK(d[2], 1'b0)
        `CHK(d[3], 1'b1)
        `CHK(`HM.addr_q.size(), 0)
        stop_test();
    end
endmodule
